/* File: core/nfh_pkg.sv */
/*
  package for the nand flash host port: command codes, address layout,
  pin timing counts and operation codes of the user side.
  assumes a 250 MHz core clock driving an asynchronous x8 nand device.
*/
package nfh_pkg;
  localparam int CLK_PERIOD_NS = 4;
  // strobe low and high phase, nanoseconds as used for the bus cycle
  localparam int STROBE_NS = 25;
  localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // read access delay before sampling the lane
  localparam int READ_ACCESS_DELAY_NS = 20;
  localparam int READ_ACCESS_DELAY_CYC =
      (READ_ACCESS_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // wait after a confirm before busy may be trusted
  localparam int BUSY_SETTLE_NS = 100;
  localparam int BUSY_SETTLE_CYC = (BUSY_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // typical busy times; the erase time sets the busy timeout limit
  localparam int PROG_TIME_US = 200;
  localparam int ERASE_TIME_US = 2000;
  localparam int TIMEOUT_CYC_DEF = ERASE_TIME_US * 1000 / CLK_PERIOD_NS * 4;

  localparam logic [7:0] CMD_READ1 = 8'h00;
  localparam logic [7:0] CMD_READ2 = 8'h30;
  localparam logic [7:0] CMD_PROG1 = 8'h80;
  localparam logic [7:0] CMD_PROG2 = 8'h10;
  localparam logic [7:0] CMD_COPY_READ2 = 8'h35;
  localparam logic [7:0] CMD_COPY_PROG1 = 8'h85;
  localparam logic [7:0] CMD_ERASE1 = 8'h60;
  localparam logic [7:0] CMD_ERASE2 = 8'hd0;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_ID = 8'h90;
  localparam logic [7:0] CMD_RESET = 8'hff;
  localparam logic [7:0] CMD_NONE = 8'h00;

  localparam int COL_BITS = 12;
  localparam int ROW_BITS = 16;
  localparam int COL_HI_BITS = 4;
  localparam logic [2:0] ADDR_BYTES_FULL = 3'h4;
  localparam logic [2:0] ADDR_BYTES_ROW = 3'h2;
  localparam logic [2:0] ADDR_BYTES_ONE = 3'h1;
  localparam logic [2:0] ADDR_FIRST_FULL = 3'h0;
  localparam logic [2:0] ADDR_FIRST_ROW = 3'h2;
  localparam int PAGE_BYTES = 2112;
  localparam int ID_BYTES = 4;

  // operations requested on the user side
  typedef enum logic [2:0] {
    NFH_OP_READ = 3'h0,
    NFH_OP_PROG = 3'h1,
    NFH_OP_ERASE = 3'h2,
    NFH_OP_STATUS = 3'h3,
    NFH_OP_ID = 3'h4,
    NFH_OP_RESET = 3'h5,
    NFH_OP_COPY = 3'h6
  } nfh_op_t;
endpackage : nfh_pkg

/* File: core/nfh_fifo.sv */
/*
  fifo of parameter width and depth with valid and ready on both sides.
  assumes one clock; depth is a power of two.
*/
module nfh_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk, // core clock
  input wire logic reset_n, // async reset, active low
  input wire logic [WIDTH-1:0] in_data, // write data
  input wire logic in_valid, // write request
  output logic in_ready, // room available
  output logic [WIDTH-1:0] out_data, // head word
  output logic out_valid, // head word present
  input wire logic out_ready // head consumed
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0] wr_reg;
  logic [AW:0] rd_reg;
  wire do_wr = in_valid && in_ready;
  wire do_rd = out_valid && out_ready;

  // full and empty from pointers carrying one extra wrap bit
  assign in_ready = !((wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]));
  assign out_valid = (wr_reg != rd_reg);
  assign out_data = mem_reg[rd_reg[AW-1:0]];

  // storage has no reset, only the pointers do
  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem_reg[wr_reg[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      if (do_wr) wr_reg <= wr_reg + 1'b1;
      if (do_rd) rd_reg <= rd_reg + 1'b1;
    end
  end
endmodule : nfh_fifo

/* File: core/nfh_host.sv */
/*
  host controller driving an asynchronous x8 nand flash through its pins.
  assumes the pins reach the device directly; ready/busy has an external
  pull-up and the lane is resolved outside from the enable.
*/
// How it works
// - command bytes sent with command latch high
// - address bytes sent with address latch high
// - four address bytes, column then row, for read, program and copy
// - upper nibble of column byte two zero
// - operations use the documented command codes
// - erase sends only two row bytes
module nfh_host
  import nfh_pkg::*;
#(
  parameter int TIMEOUT_CYC = TIMEOUT_CYC_DEF,
  parameter int FIFO_DEPTH = 32
) (
  input wire logic clk, // core clock
  input wire logic reset_n, // async reset, active low
  input wire logic op_valid, // start an operation
  input wire nfh_op_t op_code, // which operation
  input wire logic [COL_BITS-1:0] op_col, // column start within page
  input wire logic [ROW_BITS-1:0] op_row, // page address, block in top bits
  input wire logic [11:0] op_len, // bytes to move
  input wire logic op_wp_n, // write protect level to present
  output logic op_ready, // idle, accepts a start
  output logic op_done, // one-cycle pulse at end
  output logic op_timeout, // level: busy wait expired
  input wire logic [7:0] wr_data, // program data in
  input wire logic wr_valid, // program data valid
  output logic wr_ready, // program data taken
  output logic [7:0] rd_data, // read data out
  output logic rd_valid, // read data valid
  input wire logic rd_ready, // read data consumed
  output logic ce_n, // chip select pin
  output logic cle, // command latch pin
  output logic ale, // address latch pin
  output logic we_n, // write strobe pin
  output logic read_strobe_n, // read strobe pin
  output logic wp_n, // write protect pin
  output logic [7:0] io_byte_lane_o, // lane drive value
  output logic io_byte_lane_oe_n, // lane enable, low drives
  input wire logic [7:0] io_byte_lane_i, // lane as seen on the pins
  input wire logic rb_i // ready/busy pin level
);
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01, ST_CMD1 = 7'h02, ST_ADDR = 7'h04, ST_WDATA = 7'h08,
    ST_CMD2 = 7'h10, ST_BUSY = 7'h20, ST_RDATA = 7'h40
  } nfh_state_t;

  nfh_state_t st_reg, st_next;
  nfh_op_t op_reg;
  logic [COL_BITS-1:0] col_reg;
  logic [ROW_BITS-1:0] row_reg;
  logic [11:0] cnt_reg;
  logic [2:0] abyte_reg;
  logic [2:0] alast_reg;
  logic [3:0] ph_reg; // strobe phase counter
  logic half_reg; // 0 low phase, 1 high phase
  logic [$clog2(TIMEOUT_CYC+1)-1:0] wait_reg;
  logic [2:0] rb_sync_reg;
  logic rb_reg;
  logic ce_n_reg, cle_reg, ale_reg, we_n_reg, re_n_reg, oe_n_reg, wp_n_reg;
  logic [7:0] lane_reg;
  logic done_reg, tmo_reg, ready_reg;
  logic [7:0] fout_data;
  logic fout_valid, fin_ready;
  logic [7:0] cap_reg;
  logic cap_valid_reg;

  // byte for each address cycle, column first then row
  function automatic logic [7:0] addr_byte(input logic [2:0] idx,
      input logic [COL_BITS-1:0] c, input logic [ROW_BITS-1:0] r);
    case (idx)
      3'h0: addr_byte = c[7:0];
      3'h1: addr_byte = {{COL_HI_BITS{1'b0}}, c[COL_BITS-1:8]};
      3'h2: addr_byte = r[7:0];
      default: addr_byte = r[ROW_BITS-1:8];
    endcase
  endfunction : addr_byte

  // first and second command codes per operation
  function automatic logic [7:0] cmd_first(input nfh_op_t o);
    case (o)
      NFH_OP_READ: cmd_first = CMD_READ1;
      NFH_OP_PROG: cmd_first = CMD_PROG1;
      NFH_OP_ERASE: cmd_first = CMD_ERASE1;
      NFH_OP_STATUS: cmd_first = CMD_STATUS;
      NFH_OP_ID: cmd_first = CMD_ID;
      NFH_OP_COPY: cmd_first = CMD_COPY_PROG1;
      default: cmd_first = CMD_RESET;
    endcase
  endfunction : cmd_first

  function automatic logic [7:0] cmd_second(input nfh_op_t o);
    case (o)
      NFH_OP_READ: cmd_second = CMD_READ2;
      NFH_OP_ERASE: cmd_second = CMD_ERASE2;
      default: cmd_second = CMD_PROG2; // program and copy-back confirm
    endcase
  endfunction : cmd_second

  wire has_addr = (op_reg != NFH_OP_STATUS) && (op_reg != NFH_OP_RESET);
  wire has_cmd2 = (op_reg == NFH_OP_READ) || (op_reg == NFH_OP_PROG)
      || (op_reg == NFH_OP_ERASE) || (op_reg == NFH_OP_COPY);
  wire reads_out = (op_reg == NFH_OP_READ) || (op_reg == NFH_OP_STATUS)
      || (op_reg == NFH_OP_ID);
  wire ph_end = (ph_reg == 4'(STROBE_CYC - 1));
  wire cycle_end = ph_end && half_reg;
  // one clock past the access delay, still inside the strobe low phase
  wire sample_now = !half_reg && (ph_reg == 4'(READ_ACCESS_DELAY_CYC + 1));
  wire prog_blocked = !op_wp_n && ((op_code == NFH_OP_PROG) || (op_code == NFH_OP_ERASE)
      || (op_code == NFH_OP_COPY));
  wire start = op_valid && (st_reg == ST_IDLE) && !prog_blocked;
  wire wr_avail = fout_valid;
  wire busy_over = (wait_reg >= BUSY_SETTLE_CYC[$bits(wait_reg)-1:0]) && rb_reg;
  wire busy_tmo = (wait_reg == TIMEOUT_CYC[$bits(wait_reg)-1:0]);
  wire last_byte = (cnt_reg == 12'h001);
  // a data cycle waits at its start for a byte, so no strobe is cut short
  wire stall = (st_reg == ST_WDATA) && !wr_avail && !half_reg && (ph_reg == 4'h0);

  // program data buffer; its ready is the user's wr_ready
  nfh_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_wfifo (
    .clk(clk), .reset_n(reset_n),
    .in_data(wr_data), .in_valid(wr_valid), .in_ready(fin_ready),
    .out_data(fout_data), .out_valid(fout_valid),
    .out_ready(st_reg == ST_WDATA && cycle_end)
  );
  assign wr_ready = fin_ready;

  // sequencer: every pin cycle is a low phase then a high phase
  always_comb begin
    st_next = st_reg;
    case (st_reg)
      ST_IDLE: if (start) st_next = ST_CMD1;
      ST_CMD1: if (cycle_end) begin
        if (has_addr) st_next = ST_ADDR;
        else if (op_reg == NFH_OP_RESET) st_next = ST_BUSY;
        else st_next = ST_RDATA;
      end
      ST_ADDR: if (cycle_end && abyte_reg == alast_reg) begin
        if (op_reg == NFH_OP_PROG) st_next = ST_WDATA;
        else if (!has_cmd2) st_next = ST_RDATA;
        else st_next = ST_CMD2;
      end
      ST_WDATA: if (cycle_end && last_byte) st_next = ST_CMD2;
      ST_CMD2: if (cycle_end) st_next = ST_BUSY;
      ST_BUSY: if (busy_over) st_next = (op_reg == NFH_OP_READ) ? ST_RDATA : ST_IDLE;
        else if (busy_tmo) st_next = ST_IDLE;
      ST_RDATA: if (cycle_end && last_byte) st_next = ST_IDLE;
      default: st_next = ST_IDLE;
    endcase
  end

  // ready/busy through three flops, a change counts when the last two agree
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rb_sync_reg <= 3'h7;
      rb_reg <= 1'b1;
    end else begin
      rb_sync_reg <= {rb_sync_reg[1:0], rb_i};
      if (rb_sync_reg[1] == rb_sync_reg[2]) rb_reg <= rb_sync_reg[2];
    end
  end

  // phase counters and op capture
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= ST_IDLE;
      op_reg <= NFH_OP_RESET;
      col_reg <= '0;
      row_reg <= '0;
      cnt_reg <= '0;
      abyte_reg <= '0;
      alast_reg <= '0;
      ph_reg <= '0;
      half_reg <= 1'b0;
      wait_reg <= '0;
    end else begin
      st_reg <= st_next;
      ph_reg <= (ph_end || stall || st_reg == ST_IDLE || st_reg == ST_BUSY) ? 4'h0
          : ph_reg + 4'h1;
      if (ph_end) half_reg <= !half_reg;
      if (st_reg != st_next) half_reg <= 1'b0;
      wait_reg <= (st_reg == ST_BUSY) ? wait_reg + 1'b1 : '0;
      if (start) begin
        op_reg <= op_code;
        col_reg <= op_col;
        row_reg <= op_row;
        cnt_reg <= (op_code == NFH_OP_STATUS) ? 12'h001 : op_len;
        // erase sends two row bytes, id one byte, read, program and copy four
        abyte_reg <= (op_code == NFH_OP_ERASE) ? ADDR_FIRST_ROW : ADDR_FIRST_FULL;
        alast_reg <= (op_code == NFH_OP_ID) ? ADDR_FIRST_FULL
            : ADDR_FIRST_FULL + ADDR_BYTES_FULL - ADDR_BYTES_ONE;
      end else if (st_reg == ST_ADDR && cycle_end) begin
        abyte_reg <= abyte_reg + 3'h1;
      end
      if ((st_reg == ST_WDATA || st_reg == ST_RDATA) && cycle_end) cnt_reg <= cnt_reg - 12'h001;
    end
  end

  // pin drive: latches and lane set for the whole cycle, strobe in low phase
  wire in_cmd = (st_reg == ST_CMD1) || (st_reg == ST_CMD2);
  wire in_wr = in_cmd || (st_reg == ST_ADDR) || (st_reg == ST_WDATA && wr_avail);
  wire [7:0] lane_next = (st_reg == ST_CMD1) ? cmd_first(op_reg)
      : (st_reg == ST_CMD2) ? cmd_second(op_reg)
      : (st_reg == ST_ADDR) ? addr_byte(abyte_reg, col_reg, row_reg)
      : fout_data;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ce_n_reg <= 1'b1;
      cle_reg <= 1'b0;
      ale_reg <= 1'b0;
      we_n_reg <= 1'b1;
      re_n_reg <= 1'b1;
      oe_n_reg <= 1'b1;
      lane_reg <= 8'h00;
      wp_n_reg <= 1'b0;
    end else begin
      ce_n_reg <= (st_next == ST_IDLE);
      cle_reg <= in_cmd;
      ale_reg <= (st_reg == ST_ADDR);
      we_n_reg <= !(in_wr && !half_reg && !cycle_end);
      re_n_reg <= !(st_reg == ST_RDATA && !half_reg && !ph_end);
      oe_n_reg <= !in_wr;
      lane_reg <= lane_next;
      wp_n_reg <= op_wp_n;
    end
  end

  // read capture after the access delay, handed out with valid and ready
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cap_reg <= 8'h00;
      cap_valid_reg <= 1'b0;
      done_reg <= 1'b0;
      tmo_reg <= 1'b0;
      ready_reg <= 1'b1;
    end else begin
      ready_reg <= (st_reg == ST_IDLE) && (st_next == ST_IDLE);
      if (st_reg == ST_RDATA && sample_now) begin
        cap_reg <= io_byte_lane_i;
        cap_valid_reg <= 1'b1;
      end else if (rd_ready) begin
        cap_valid_reg <= 1'b0;
      end
      done_reg <= (st_reg != ST_IDLE) && (st_next == ST_IDLE);
      if (start) tmo_reg <= 1'b0;
      else if (st_reg == ST_BUSY && busy_tmo) tmo_reg <= 1'b1;
    end
  end

  assign ce_n = ce_n_reg;
  assign cle = cle_reg;
  assign ale = ale_reg;
  assign we_n = we_n_reg;
  assign read_strobe_n = re_n_reg;
  assign wp_n = wp_n_reg;
  assign io_byte_lane_o = lane_reg;
  assign io_byte_lane_oe_n = oe_n_reg;
  assign op_ready = ready_reg;
  assign op_done = done_reg;
  assign op_timeout = tmo_reg;
  assign rd_data = cap_reg;
  assign rd_valid = cap_valid_reg;

  // never drive the lane while the read strobe is low
  lane_contend_a: assert property (@(posedge clk) disable iff (!reset_n)
    !read_strobe_n |-> io_byte_lane_oe_n) else $error("lane driven during read strobe");
  latch_excl_a: assert property (@(posedge clk) disable iff (!reset_n)
    !(cle && ale)) else $error("both latches high");
  cmd_has_cle_a: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(cle) |-> ##1 (io_byte_lane_oe_n == 1'b0)) else $error("command not driven");
  col_hi_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
    (st_reg == ST_ADDR && abyte_reg == 3'h1) |=> io_byte_lane_o[7:4] == 4'h0)
    else $error("column high nibble not zero");
  erase_rows_a: assert property (@(posedge clk) disable iff (!reset_n)
    (st_reg == ST_ADDR && op_reg == NFH_OP_ERASE) |-> abyte_reg >= ADDR_FIRST_ROW)
    else $error("erase sent a column byte");
  wp_block_a: assert property (@(posedge clk) disable iff (!reset_n)
    (op_valid && st_reg == ST_IDLE && prog_blocked) |=> st_reg == ST_IDLE)
    else $error("protected operation started");
  busy_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
    (st_reg == ST_BUSY && !rb_reg && !busy_tmo) |=> st_reg == ST_BUSY)
    else $error("left busy before ready");
  strobe_width_a: assert property (@(posedge clk) disable iff (!reset_n)
    $fell(we_n) |=> !we_n) else $error("write strobe too short");
  rdata_op_a: assert property (@(posedge clk) disable iff (!reset_n)
    st_reg == ST_RDATA |-> reads_out) else $error("read strobes for a write operation");
  cov_read_c: cover property (@(posedge clk) st_reg == ST_RDATA && op_reg == NFH_OP_READ);
  cov_prog_c: cover property (@(posedge clk) st_reg == ST_WDATA ##1 st_reg == ST_CMD2);
  cov_erase_c: cover property (@(posedge clk) st_reg == ST_BUSY && op_reg == NFH_OP_ERASE);
endmodule : nfh_host

/* File: tb/nfh_dev_model.sv */
/*
  behavioural x8 nand device facing the host port in the bench.
  assumes the bench resolves the lane; ready/busy is driven high and low here.
*/
module nfh_dev_model #(
  parameter int PROG_NS = 2000, // program busy, shortened to keep runs short
  parameter int ERASE_NS = 4000, // erase busy, shortened the same way
  parameter int READ_NS = 400, // array read busy
  parameter int ACC_NS = 20 // read access delay
) (
  input wire logic ce_n, // chip select
  input wire logic cle, // command latch
  input wire logic ale, // address latch
  input wire logic we_n, // write strobe
  input wire logic read_strobe_n, // read strobe
  input wire logic wp_n, // write protect
  input wire logic [7:0] lane, // resolved lane
  output logic [7:0] dev_lane, // device side of the lane
  output logic rb // ready/busy, low while busy
);
  timeunit 1ns;
  timeprecision 100ps;
  // id bytes: arbitrary values
  localparam logic [7:0] ID_B [4] = '{8'h5a, 8'ha5, 8'h3c, 8'hc3};
  logic [7:0] mem [int];
  logic [7:0] pbuf [0:4095];
  logic [7:0] ab [0:3];
  logic [7:0] cmd, out_v, rq;
  logic [11:0] col, ccol;
  logic [15:0] prow, erow;
  logic [1:0] mode;
  logic busy, drive;
  int acnt, idx, viol, busy_ns;

  function automatic int key(input int r, input int c);
    return r * 4096 + c;
  endfunction : key

  // busy runs on its own once started, no host help needed
  task automatic go(input int ns);
    busy_ns = ns;
    busy = 1'b1;
  endtask : go

  initial begin
    busy = 0; drive = 0; out_v = 8'h00; acnt = 0; idx = 0; viol = 0; mode = 0; cmd = 8'hff;
    for (int i = 0; i < 4; i++) ab[i] = 8'h00;
    for (int c = 0; c < 4096; c++) pbuf[c] = 8'hff;
  end

  // address layout: column then row, erase takes rows only
  assign ccol = {ab[1][3:0], ab[0]};
  assign prow = {ab[3], ab[2]};
  assign erow = {ab[1], ab[0]};
  // driven high and low, reports regardless of chip select; lane shows junk when released
  assign rb = !busy;
  assign dev_lane = drive ? out_v : ~out_v;

  // busy ends by time alone, chip select high does not cut it short
  always @(posedge busy) begin
    #(busy_ns);
    busy = 1'b0;
  end

  // latch command, address or data on the write strobe rise
  always @(posedge we_n) begin
    if (ce_n === 1'b0 && cle === 1'b1) begin
      if (busy && lane != 8'h70 && lane != 8'hff) viol++;
      cmd = lane;
      case (lane)
        8'h00, 8'h60, 8'h85, 8'h90: begin
          acnt = 0;
          idx = 0;
          mode = (lane == 8'h90) ? 2'd2 : 2'd0;
        end
        8'h80: begin
          acnt = 0;
          mode = 2'd0;
          for (int c = 0; c < 4096; c++) pbuf[c] = 8'hff;
        end
        8'h30, 8'h35: begin
          for (int c = 0; c < 2112; c++)
            pbuf[c] = mem.exists(key(prow, c)) ? mem[key(prow, c)] : 8'hff;
          col = ccol;
          go(READ_NS);
        end
        8'h10: begin
          if (wp_n) for (int c = 0; c < 2112; c++) mem[key(prow, c)] = pbuf[c];
          go(PROG_NS);
        end
        8'hd0: begin
          if (wp_n) for (int p = 0; p < 64; p++) for (int c = 0; c < 2112; c++)
            mem.delete(key(erow - erow % 64 + p, c));
          go(ERASE_NS);
        end
        8'h70: mode = 2'd1;
        8'hff: go(200);
        default: ;
      endcase
    end else if (ce_n === 1'b0 && ale === 1'b1) begin
      if (acnt < 4) ab[acnt] = lane;
      if (acnt == 1 && cmd != 8'h60 && lane[7:4] != 4'h0) viol++;
      acnt++;
      col = ccol;
    end else if (ce_n === 1'b0) begin
      pbuf[col] = lane;
      col++;
    end
  end

  // host must not write while the device drives
  always @(negedge we_n) if (drive) viol++;

  // each read strobe fall gives one byte after the access delay; chip select toggles keep state
  always @(negedge read_strobe_n) if (ce_n === 1'b0) begin
    case (mode)
      2'd1: rq = {1'b1, !busy, 6'h20};
      2'd2: begin rq = ID_B[idx % 4]; idx++; end
      default: begin rq = pbuf[col]; col++; end
    endcase
    #(ACC_NS);
    out_v = rq;
    drive = 1'b1;
  end

  // release when deselected or strobe ends
  always @(posedge read_strobe_n or posedge ce_n) drive = 1'b0;
endmodule : nfh_dev_model

/* File: tb/tb.sv */
/*
  self-checking bench of the nand host port against a behavioural device.
  assumes nfh_pkg, nfh_fifo and nfh_host are compiled first.
*/
module tb
  import nfh_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, reset_n, op_valid, op_wp_n, wr_valid, rd_ready;
  nfh_op_t op_code;
  logic [11:0] op_col, op_len;
  logic [15:0] op_row;
  logic [7:0] wr_data, rd_data, host_o, dev_lane, lane;
  logic op_ready, op_done, op_timeout, wr_ready, rd_valid, ce_n, cle, ale, we_n;
  logic read_strobe_n, wp_n, host_oe_n, rb;
  logic [7:0] rdq [$];
  int mismatches, total_checks, cyc;

  nfh_host #(.TIMEOUT_CYC(2000), .FIFO_DEPTH(32)) i_nfh_host (.clk(clk), .reset_n(reset_n),
    .op_valid(op_valid), .op_code(op_code), .op_col(op_col), .op_row(op_row), .op_len(op_len),
    .op_wp_n(op_wp_n), .op_ready(op_ready), .op_done(op_done), .op_timeout(op_timeout),
    .wr_data(wr_data), .wr_valid(wr_valid), .wr_ready(wr_ready), .rd_data(rd_data),
    .rd_valid(rd_valid), .rd_ready(rd_ready), .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
    .read_strobe_n(read_strobe_n), .wp_n(wp_n), .io_byte_lane_o(host_o),
    .io_byte_lane_oe_n(host_oe_n), .io_byte_lane_i(lane), .rb_i(rb));
  nfh_dev_model i_nfh_dev_model (.ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
    .read_strobe_n(read_strobe_n), .wp_n(wp_n), .lane(lane), .dev_lane(dev_lane), .rb(rb));

  // lane level: host when its enable is low, device side otherwise
  assign lane = host_oe_n ? dev_lane : host_o;

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // gather read bytes as the handshake takes them, mid-cycle, clear of the edges
  always @(negedge clk) if (rd_valid === 1'b1 && rd_ready === 1'b1) rdq.push_back(rd_data);

  // hang guard, about five times the expected run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      mismatches++;
      $display("CHECK FAILED run time expected under 30000 cycles seen %0d", cyc);
      results();
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results

  // one operation from start to its done pulse
  task automatic run_op(input nfh_op_t code, input logic [11:0] c, input logic [15:0] r,
      input logic [11:0] n);
    int k;
    rdq.delete();
    k = 0;
    while (op_ready !== 1'b1 && k < 100) begin @(posedge clk); #1; k++; end
    op_code = code; op_col = c; op_row = r; op_len = n; op_wp_n = 1'b1; op_valid = 1'b1;
    @(posedge clk);
    #1 op_valid = 1'b0;
    k = 0;
    while (op_done !== 1'b1 && k < 4000) begin @(posedge clk); #1; k++; end
    chk("op_done", 16'h1, {15'h0, op_done});
    chk("op_timeout", 16'h0, {15'h0, op_timeout});
  endtask : run_op

  // feed n program bytes counting up from base
  task automatic push_n(input int n, input logic [7:0] base);
    for (int i = 0; i < n; i++) begin
      wr_data = base + 8'(i);
      wr_valid = 1'b1;
      while (wr_ready !== 1'b1) begin @(posedge clk); #1; end
      @(posedge clk);
      #1;
    end
    wr_valid = 1'b0;
  endtask : push_n

  task automatic chk_rd(input int n, input logic [7:0] base);
    chk("read count", 16'(n), 16'(rdq.size()));
    for (int i = 0; i < n; i++) chk("read byte", {8'h0, base + 8'(i)}, {8'h0, rdq[i]});
  endtask : chk_rd

  task automatic t_prog_read();
    push_n(4, 8'ha0);
    run_op(NFH_OP_PROG, 12'h005, 16'h0041, 12'h004);
    chk("addr col lo", 16'h05, {8'h0, i_nfh_dev_model.ab[0]});
    chk("addr col hi", 16'h00, {8'h0, i_nfh_dev_model.ab[1]});
    chk("addr row", 16'h0041, {i_nfh_dev_model.ab[3], i_nfh_dev_model.ab[2]});
    run_op(NFH_OP_READ, 12'h005, 16'h0041, 12'h004);
    chk_rd(4, 8'ha0);
    $display("test prog_read done");
  endtask : t_prog_read

  task automatic t_fifo();
    push_n(32, 8'h10);
    @(posedge clk);
    #1 chk("wr_ready when full", 16'h0, {15'h0, wr_ready});
    run_op(NFH_OP_PROG, 12'h000, 16'h0080, 12'h020);
    chk("wr_ready drained", 16'h1, {15'h0, wr_ready});
    run_op(NFH_OP_READ, 12'h000, 16'h0080, 12'h020);
    chk_rd(32, 8'h10);
    $display("test fifo done");
  endtask : t_fifo

  task automatic t_copy();
    run_op(NFH_OP_READ, 12'h000, 16'h0080, 12'h001);
    run_op(NFH_OP_COPY, 12'h000, 16'h00c1, 12'h001);
    chk("copy command", 16'h10, {8'h0, i_nfh_dev_model.cmd});
    run_op(NFH_OP_READ, 12'h000, 16'h00c1, 12'h020);
    chk_rd(32, 8'h10);
    $display("test copy done");
  endtask : t_copy

  task automatic t_erase();
    int k;
    op_code = NFH_OP_ERASE; op_row = 16'h0040; op_wp_n = 1'b0; op_valid = 1'b1;
    k = 0;
    repeat (20) begin
      @(posedge clk);
      #1;
      if (ce_n !== 1'b1 || op_ready !== 1'b1) k++;
    end
    op_valid = 1'b0;
    @(posedge clk);
    #1;
    chk("protected start", 16'h0, 16'(k));
    run_op(NFH_OP_READ, 12'h005, 16'h0041, 12'h001);
    chk_rd(1, 8'ha0);
    run_op(NFH_OP_ERASE, 12'h000, 16'h0040, 12'h001);
    chk("erase addr count", 16'h2, 16'(i_nfh_dev_model.acnt));
    chk("erase row", 16'h0040, {i_nfh_dev_model.ab[1], i_nfh_dev_model.ab[0]});
    run_op(NFH_OP_READ, 12'h005, 16'h0041, 12'h001);
    chk_rd(1, 8'hff);
    run_op(NFH_OP_READ, 12'h000, 16'h0080, 12'h001);
    chk_rd(1, 8'h10);
    $display("test erase done");
  endtask : t_erase

  task automatic t_stat_id();
    rd_ready = 1'b0;
    run_op(NFH_OP_STATUS, 12'h000, 16'h0000, 12'h001);
    chk("rd_valid held", 16'h1, {15'h0, rd_valid});
    rd_ready = 1'b1;
    @(posedge clk);
    #1 chk("rd_valid taken", 16'h0, {15'h0, rd_valid});
    chk_rd(1, 8'he0);
    run_op(NFH_OP_ID, 12'h000, 16'h0000, 12'h004);
    chk("id addr count", 16'h1, 16'(i_nfh_dev_model.acnt));
    chk("id count", 16'h4, 16'(rdq.size()));
    for (int i = 0; i < 4; i++)
      chk("id byte", {8'h0, i_nfh_dev_model.ID_B[i]}, {8'h0, rdq[i]});
    run_op(NFH_OP_RESET, 12'h000, 16'h0000, 12'h001);
    chk("reset command", 16'hff, {8'h0, i_nfh_dev_model.cmd});
    $display("test status_id_reset done");
  endtask : t_stat_id

  initial begin
    op_valid = 0; op_code = NFH_OP_READ; op_col = 0; op_row = 0; op_len = 1; op_wp_n = 1;
    wr_data = 0; wr_valid = 0; rd_ready = 1; reset_n = 0; mismatches = 0; total_checks = 0;
    cyc = 0;
    repeat (10) @(posedge clk);
    #1 reset_n = 1'b1;
    t_prog_read();
    t_fifo();
    t_copy();
    t_erase();
    t_stat_id();
    chk("device side faults", 16'h0, 16'(i_nfh_dev_model.viol));
    results();
  end
endmodule : tb
